// ---- src/fcs_map.svh ----
// register offsets, field positions, reset values and timing for the flash clock/security bank
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// register offsets on the plain register port
`define FCS_OFF_DIVIDER 5'h00
`define FCS_OFF_SECURITY 5'h01

// timebase divider register fields
`define FCS_DIV_LOADED_BIT 7
`define FCS_DIV_VALUE_MSB 6
`define FCS_DIV_VALUE_LSB 0
`define FCS_DIV_VALUE_RST 7'h00

// security register fields
`define FCS_KEYEN_MSB 7
`define FCS_KEYEN_LSB 6
`define FCS_LOCK_MSB 1
`define FCS_LOCK_LSB 0
`define FCS_KEYEN_ENABLED 2'h2
`define FCS_LOCK_UNSECURED 2'h2
`define FCS_SEC_ALL_SET 8'hff
`define FCS_SEC_RST 8'hff

// timebase target and oscillator figures
`define FCS_TIMEBASE_TARGET_KHZ 1000
`define FCS_OSC_CLOCK_KHZ 40000
`define FCS_DIV_NOMINAL (`FCS_OSC_CLOCK_KHZ / `FCS_TIMEBASE_TARGET_KHZ)
// recommended code for the 39.90 to 40.95 MHz oscillator band
`define FCS_DIV_CODE_OSC40 7'h26

`endif

// ---- src/fcs_pkg.sv ----
// types shared by the flash clock and security register bank
`default_nettype none
package fcs_pkg;

  // register port request, one cycle per strobe
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fcs_bus_req_type;

  // phase of the security byte load
  typedef enum logic [0:0] {
    SEC_WAIT_LOAD,
    SEC_LOADED
  } fcs_sec_phase_type;

  // whole state of the bank
  typedef struct packed {
    logic [6:0] divide_value;
    logic divider_loaded_flag;
    logic [6:0] div_cnt;
    logic tick;
    logic [7:0] security_state_reg;
    fcs_sec_phase_type sec_phase;
    logic key_enabled;
    logic unsecured;
    logic [7:0] rd_data;
  } fcs_state_type;

endpackage
`default_nettype wire

// ---- src/fcs_flash_clock_sec.sv ----
// flash timebase divider and security register bank with register port
//
// Overview of operation
// - loaded flag bit 7 shows divider written
// - all bits readable, value write once, bit7 fixed
// - divide oscillator clock by value for timebase
// - divider writes accepted during reset sequence
// - security register readable, writes ignored
// - security register loaded from nonvolatile byte
// - double-bit fault at load sets all bits
// - backdoor enabled only for key field 10
// - unsecured only when lock field is 10
// - backdoor unlock forces lock field to 10
//
// Chosen here: the plain strobed port.
`include "fcs_map.svh"
`default_nettype none

module fcs_flash_clock_sec
  import fcs_pkg::*;
(
  input wire logic sys_clk_i,                 // oscillator clock
  input wire logic reset_n_i,                 // async reset, active low
  input wire fcs_bus_req_type bus_req_i,      // register port request
  output logic [7:0] rd_data_o,               // read data, cycle after read
  input wire logic command_complete_flag_i,   // high when no command runs
  input wire logic reset_seq_active_i,        // flash reset sequence running
  input wire logic nv_load_i,                 // security byte phrase read done
  input wire logic [7:0] nv_sec_byte_i,       // security byte from flash
  input wire logic nv_dbl_fault_i,            // double-bit fault on that phrase
  input wire logic backdoor_unlock_i,         // backdoor key verified pulse
  output logic program_timebase_tick_o,       // one pulse per timebase period
  output logic divider_loaded_flag_o,         // divider has been written
  output logic [6:0] divide_value_o,          // programmed divide value
  output logic [7:0] security_state_o,        // security register contents
  output logic backdoor_key_enable_o,         // backdoor access allowed
  output logic chip_unsecured_o               // device is unsecured
);

  // current and next state of the whole bank
  fcs_state_type state_q;
  fcs_state_type state_d;

  // decoded strobes
  logic div_sel;
  logic sec_sel;
  logic div_wr_ok;
  logic [7:0] div_rd_word;

  // address decode and write acceptance
  always_comb begin
    div_sel = (bus_req_i.addr == `FCS_OFF_DIVIDER);
    sec_sel = (bus_req_i.addr == `FCS_OFF_SECURITY);
    // accepted when idle or in the reset sequence, and only once
    div_wr_ok = bus_req_i.wr && div_sel && !state_q.divider_loaded_flag &&
                (command_complete_flag_i || reset_seq_active_i);
    div_rd_word = {state_q.divider_loaded_flag, state_q.divide_value};
  end

  // next-state logic
  always_comb begin
    state_d = state_q;
    // divider write: value stored once, flag sets, bit 7 of data dropped
    if (div_wr_ok) begin
      state_d.divide_value = bus_req_i.wdata[`FCS_DIV_VALUE_MSB:`FCS_DIV_VALUE_LSB];
      state_d.divider_loaded_flag = 1'b1;
    end
    // timebase counter runs only with a nonzero loaded value
    state_d.tick = 1'b0;
    if (!state_q.divider_loaded_flag || (state_q.divide_value == 7'h00)) begin
      state_d.div_cnt = 7'h00;
    end else if (state_q.div_cnt >= state_q.divide_value - 7'h01) begin
      // wrap and emit one tick per divide_value cycles
      state_d.div_cnt = 7'h00;
      state_d.tick = 1'b1;
    end else begin
      state_d.div_cnt = state_q.div_cnt + 7'h01;
    end
    // security byte load, once per reset
    case (state_q.sec_phase)
      SEC_WAIT_LOAD: begin
        if (nv_load_i) begin
          if (nv_dbl_fault_i) begin
            state_d.security_state_reg = `FCS_SEC_ALL_SET;
          end else begin
            state_d.security_state_reg = nv_sec_byte_i;
          end
          state_d.sec_phase = SEC_LOADED;
        end
      end
      SEC_LOADED: begin
        // backdoor unlock only honoured while key access is enabled
        if (backdoor_unlock_i && state_q.key_enabled) begin
          state_d.security_state_reg[`FCS_LOCK_MSB:`FCS_LOCK_LSB] =
            `FCS_LOCK_UNSECURED;
        end
      end
      default: begin
        state_d.sec_phase = SEC_WAIT_LOAD;
      end
    endcase
    // software writes to the security register change nothing
    // decoded security outputs follow the next register value
    state_d.key_enabled =
      (state_d.security_state_reg[`FCS_KEYEN_MSB:`FCS_KEYEN_LSB] == `FCS_KEYEN_ENABLED);
    state_d.unsecured =
      (state_d.security_state_reg[`FCS_LOCK_MSB:`FCS_LOCK_LSB] == `FCS_LOCK_UNSECURED);
    // read data for one cycle only, zero otherwise or when unmapped
    state_d.rd_data = 8'h00;
    if (bus_req_i.rd) begin
      if (div_sel) begin
        state_d.rd_data = div_rd_word;
      end else if (sec_sel) begin
        state_d.rd_data = state_q.security_state_reg;
      end else begin
        state_d.rd_data = 8'h00;
      end
    end
  end

  // state register, cleared only by reset, except the security register, which reset sets to all ones
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q.divide_value <= `FCS_DIV_VALUE_RST;
      state_q.divider_loaded_flag <= 1'b0;
      state_q.div_cnt <= 7'h00;
      state_q.tick <= 1'b0;
      state_q.security_state_reg <= `FCS_SEC_RST;
      state_q.sec_phase <= SEC_WAIT_LOAD;
      state_q.key_enabled <= 1'b0;
      state_q.unsecured <= 1'b0;
      state_q.rd_data <= 8'h00;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state
  assign rd_data_o = state_q.rd_data;
  assign program_timebase_tick_o = state_q.tick;
  assign divider_loaded_flag_o = state_q.divider_loaded_flag;
  assign divide_value_o = state_q.divide_value;
  assign security_state_o = state_q.security_state_reg;
  assign backdoor_key_enable_o = state_q.key_enabled;
  assign chip_unsecured_o = state_q.unsecured;

  // helper: cycles since the previous tick, for period checks
  logic [7:0] gap_q;
  logic seen_tick_q;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_q <= 8'h00;
      seen_tick_q <= 1'b0;
    end else if (program_timebase_tick_o) begin
      gap_q <= 8'h01;
      seen_tick_q <= 1'b1;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  // the loaded flag reads back in bit 7 of the divider register
  chk_loaded_flag_read: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.rd && div_sel |=> rd_data_o[`FCS_DIV_LOADED_BIT] == $past(divider_loaded_flag_o))
    else $error("loaded flag misread");

  // an accepted divider write sets the flag and stores the value
  chk_div_write_takes: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    div_wr_ok |=> divider_loaded_flag_o && divide_value_o == $past(bus_req_i.wdata[6:0]))
    else $error("divider write not taken");

  // once loaded, value and flag never change until reset
  chk_write_once: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    divider_loaded_flag_o |=> divider_loaded_flag_o && $stable(divide_value_o))
    else $error("divider changed after load");

  // tick period equals the divide value
  chk_tick_period: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    program_timebase_tick_o && seen_tick_q && $stable(divide_value_o) && divide_value_o != 7'h00
    |-> gap_q == {1'b0, divide_value_o})
    else $error("timebase period wrong");

  // no tick without a loaded nonzero value
  chk_tick_needs_value: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (!divider_loaded_flag_o || divide_value_o == 7'h00) |=> !program_timebase_tick_o)
    else $error("tick without divider");

  // a write in the reset sequence is taken although no command is complete
  chk_reset_seq_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && div_sel && reset_seq_active_i && !divider_loaded_flag_o
    |=> divider_loaded_flag_o)
    else $error("reset-sequence write lost");

  // a write during a running command outside the reset sequence is ignored
  chk_busy_write_dropped: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && div_sel && !command_complete_flag_i && !reset_seq_active_i &&
    !divider_loaded_flag_o |=> !divider_loaded_flag_o)
    else $error("busy write was taken");

  // software writes leave the security register as it was
  chk_sec_read_only: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && sec_sel && !nv_load_i && !backdoor_unlock_i
    |=> $stable(security_state_o))
    else $error("security register written");

  // the nonvolatile byte lands in the register at load
  chk_sec_load: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_WAIT_LOAD && nv_load_i && !nv_dbl_fault_i
    |=> security_state_o == $past(nv_sec_byte_i))
    else $error("security byte not loaded");

  // a double-bit fault leaves every bit set, secured, key disabled
  chk_sec_fault: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_WAIT_LOAD && nv_load_i && nv_dbl_fault_i
    |=> security_state_o == 8'hff && !chip_unsecured_o && !backdoor_key_enable_o)
    else $error("fault load not all ones");

  // backdoor enable follows the key field exactly
  chk_key_decode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    backdoor_key_enable_o == (security_state_o[7:6] == 2'b10))
    else $error("key enable decode wrong");

  // unsecured follows the lock field exactly
  chk_lock_decode: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    chip_unsecured_o == (security_state_o[1:0] == 2'b10))
    else $error("lock decode wrong");

  // backdoor unlock forces the lock field and leaves the key field alone
  chk_backdoor_force: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_LOADED && backdoor_unlock_i && backdoor_key_enable_o
    |=> chip_unsecured_o ##0 security_state_o[7:2] == $past(security_state_o[7:2]))
    else $error("backdoor unlock not applied");

  // read data stands one cycle only
  chk_read_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !bus_req_i.rd |=> rd_data_o == 8'h00)
    else $error("read data held too long");

  // a write after the load leaves the value alone
  chk_locked_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && div_sel && divider_loaded_flag_o |=> $stable(divide_value_o))
    else $error("locked divider overwritten");

  // the flag only rises through an accepted write
  chk_flag_needs_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !divider_loaded_flag_o && !div_wr_ok |=> !divider_loaded_flag_o)
    else $error("flag set without write");

  // the value stays at zero until the first write
  chk_value_before_load: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !divider_loaded_flag_o |-> divide_value_o == 7'h00)
    else $error("value before load");

  // an idle write before the load is taken with bit 7 dropped
  chk_idle_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && div_sel && command_complete_flag_i && !divider_loaded_flag_o
    |=> divider_loaded_flag_o && divide_value_o == $past(bus_req_i.wdata[6:0]))
    else $error("idle divider write lost");

  // a busy write outside the reset sequence keeps the value
  chk_busy_value_kept: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && div_sel && !command_complete_flag_i && !reset_seq_active_i
    |=> $stable(divide_value_o))
    else $error("busy write changed value");

  // writes to other addresses leave the divider alone
  chk_other_write: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && !div_sel |=> $stable(divide_value_o) && $stable(divider_loaded_flag_o))
    else $error("stray write hit divider");

  // divider readback carries the value bits
  chk_read_divider: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.rd && div_sel |=> rd_data_o[6:0] == $past(divide_value_o))
    else $error("divider value misread");

  // security readback shows the whole register
  chk_read_security: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.rd && sec_sel |=> rd_data_o == $past(security_state_o))
    else $error("security register misread");

  // unmapped reads return zero
  chk_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.rd && !div_sel && !sec_sel |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");

  // a write strobe brings no read data
  chk_write_no_data: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr |=> rd_data_o == 8'h00)
    else $error("read data after write");

  // tick is one cycle wide unless the value is one
  chk_tick_width: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    program_timebase_tick_o && divide_value_o != 7'h01 |=> !program_timebase_tick_o)
    else $error("tick too wide");

  // the counter stays below the divide value
  chk_counter_range: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    divider_loaded_flag_o && divide_value_o != 7'h00 |-> state_q.div_cnt < divide_value_o)
    else $error("timebase counter overran");

  // ticks never come closer than the divide value
  chk_tick_gap_min: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    program_timebase_tick_o && seen_tick_q |-> gap_q >= {1'b0, divide_value_o})
    else $error("ticks too close");

  // later load pulses are ignored
  chk_load_once: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_LOADED && nv_load_i && !backdoor_unlock_i
    |=> $stable(security_state_o))
    else $error("second load taken");

  // before the load the register reads all ones
  chk_before_load: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_WAIT_LOAD |-> security_state_o == 8'hff)
    else $error("security changed before load");

  // before the load the chip is secured with the key off
  chk_secured_early: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_WAIT_LOAD |-> !chip_unsecured_o && !backdoor_key_enable_o)
    else $error("unsecured before load");

  // an unlock with the key disabled changes nothing
  chk_unlock_needs_key: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_LOADED && backdoor_unlock_i && !backdoor_key_enable_o
    |=> $stable(security_state_o))
    else $error("unlock with key disabled");

  // an unlock before the load changes nothing
  chk_unlock_early: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_q.sec_phase == SEC_WAIT_LOAD && backdoor_unlock_i && !nv_load_i
    |=> $stable(security_state_o))
    else $error("unlock before load");

  // scenarios worth seeing
  cov_divider_written: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    div_wr_ok ##1 divider_loaded_flag_o);
  cov_two_ticks: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    program_timebase_tick_o && seen_tick_q);
  cov_fault_load: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    nv_load_i && nv_dbl_fault_i && state_q.sec_phase == SEC_WAIT_LOAD);
  cov_backdoor_unlock: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    backdoor_unlock_i && backdoor_key_enable_o ##1 chip_unsecured_o);
  cov_busy_write: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    bus_req_i.wr && div_sel && !command_complete_flag_i && !reset_seq_active_i);

endmodule
`default_nettype wire

// ---- verif/fcs_flash_clock_sec_bench.sv ----
// self-checking bench for the flash timebase divider and security register bank
`include "fcs_map.svh"
`default_nettype none

module fcs_flash_clock_sec_bench
  import fcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk_i = 1'b0; // oscillator clock, 40 MHz
  logic reset_n_i = 1'b0; // async reset, active low
  fcs_bus_req_type bus_req_i = '0; // register port request
  logic command_complete_flag_i = 1'b1;
  logic reset_seq_active_i = 1'b0;
  logic nv_load_i = 1'b0;
  logic [7:0] nv_sec_byte_i = 8'h00;
  logic nv_dbl_fault_i = 1'b0;
  logic backdoor_unlock_i = 1'b0;
  logic [7:0] rd_data_o;
  logic program_timebase_tick_o;
  logic divider_loaded_flag_o;
  logic [6:0] divide_value_o;
  logic [7:0] security_state_o;
  logic backdoor_key_enable_o;
  logic chip_unsecured_o;
  int failures = 0; // mismatches seen
  int check_count = 0; // comparisons made
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic rd_pend = 1'b0; // read taken at the last edge
  logic [7:0] b; // security byte under test
  logic [7:0] e; // expected security value
  logic [6:0] v; // divide value under test

  fcs_flash_clock_sec dut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req_i),
    .rd_data_o(rd_data_o), .command_complete_flag_i(command_complete_flag_i),
    .reset_seq_active_i(reset_seq_active_i), .nv_load_i(nv_load_i),
    .nv_sec_byte_i(nv_sec_byte_i), .nv_dbl_fault_i(nv_dbl_fault_i),
    .backdoor_unlock_i(backdoor_unlock_i),
    .program_timebase_tick_o(program_timebase_tick_o),
    .divider_loaded_flag_o(divider_loaded_flag_o), .divide_value_o(divide_value_o),
    .security_state_o(security_state_o), .backdoor_key_enable_o(backdoor_key_enable_o),
    .chip_unsecured_o(chip_unsecured_o)
  );

  // free-running clock, 25 ns period
  always #12.5 sys_clk_i = ~sys_clk_i;

  // verdict and end of run
  task final_report();
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one comparison, mismatch reported at once
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // reset held for 8 cycles
  task do_reset();
    reset_n_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
  endtask

  // one-cycle write strobe
  task wr_reg(input logic [4:0] a, input logic [7:0] d);
    bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_req_i <= '0;
  endtask

  // one-cycle read strobe, expectation noted for the monitor
  task rd_reg(input logic [4:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_req_i <= '0;
    @(posedge sys_clk_i);
  endtask

  // one-cycle pulse on a control input
  task pulse(input int which);
    if (which == 0) nv_load_i <= 1'b1;
    else backdoor_unlock_i <= 1'b1;
    @(posedge sys_clk_i);
    nv_load_i <= 1'b0;
    backdoor_unlock_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // bounded wait for a tick, then the cycles to the next one
  task tick_gap(input logic [6:0] exp);
    int n;
    n = 0;
    while (program_timebase_tick_o !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
      if (n > 300) begin
        failures++;
        final_report();
      end
    end
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (program_timebase_tick_o !== 1'b1 && n < 300);
    chk(8'(n), {1'b0, exp});
  endtask

  // monitor: read data stand only in the cycle after the strobe
  always @(posedge sys_clk_i) rd_pend <= (bus_req_i.rd === 1'b1);
  always @(negedge sys_clk_i) begin
    if (rd_pend && exp_q.size() > 0) begin
      chk(rd_data_o, exp_q.pop_front());
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'hea1d));
    do_reset();
    rd_reg(`FCS_OFF_DIVIDER, 8'h00);
    rd_reg(`FCS_OFF_SECURITY, `FCS_SEC_RST);
    rd_reg(5'h1f, 8'h00);
    pulse(1); // unlock before the load is ignored
    nv_sec_byte_i <= 8'($urandom);
    nv_dbl_fault_i <= 1'b1;
    pulse(0);
    nv_dbl_fault_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(security_state_o, `FCS_SEC_ALL_SET);
    chk({7'h00, backdoor_key_enable_o}, 8'h00);
    @(posedge sys_clk_i);
    command_complete_flag_i <= 1'b0;
    wr_reg(`FCS_OFF_DIVIDER, 8'h05);
    rd_reg(`FCS_OFF_DIVIDER, 8'h00);
    reset_seq_active_i <= 1'b1;
    wr_reg(`FCS_OFF_DIVIDER, {1'b1, `FCS_DIV_CODE_OSC40});
    rd_reg(`FCS_OFF_DIVIDER, {1'b1, `FCS_DIV_CODE_OSC40});
    reset_seq_active_i <= 1'b0;
    command_complete_flag_i <= 1'b1;
    wr_reg(`FCS_OFF_DIVIDER, 8'h11);
    rd_reg(`FCS_OFF_DIVIDER, {1'b1, `FCS_DIV_CODE_OSC40});
    chk({7'h00, divider_loaded_flag_o}, 8'h01);
    tick_gap(`FCS_DIV_CODE_OSC40);
    @(posedge sys_clk_i);
    do_reset();
    chk({7'h00, divider_loaded_flag_o}, 8'h00);
    v = 7'(2 + $urandom % 8);
    wr_reg(`FCS_OFF_DIVIDER, {1'b1, v});
    rd_reg(`FCS_OFF_DIVIDER, {1'b1, v});
    chk({1'b0, divide_value_o}, {1'b0, v});
    tick_gap(v);
    tick_gap(v);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      do_reset();
      // reserved bits erased, key 01 and lock 01 among the codes
      b = {2'(i), 4'hf, 2'(3 - i)};
      nv_sec_byte_i <= b;
      pulse(0);
      nv_sec_byte_i <= ~b;
      pulse(0);
      @(negedge sys_clk_i);
      chk(security_state_o, b);
      chk({7'h00, backdoor_key_enable_o}, {7'h00, i == 2});
      chk({7'h00, chip_unsecured_o}, {7'h00, i == 1});
      @(posedge sys_clk_i);
      wr_reg(`FCS_OFF_SECURITY, ~b);
      rd_reg(`FCS_OFF_SECURITY, b);
      e = (i == 2) ? {b[7:2], `FCS_LOCK_UNSECURED} : b;
      pulse(1);
      @(negedge sys_clk_i);
      chk(security_state_o, e);
      chk({7'h00, chip_unsecured_o}, {7'h00, e[1:0] == 2'h2});
    end
    repeat (3) @(posedge sys_clk_i);
    chk(8'(exp_q.size()), 8'h00);
    final_report();
  end
endmodule

`default_nettype wire
